// File: mck_pkg.sv
package mck_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] MCK_ADDR_CTRL1 = 32'h0000_0000;
  localparam logic [31:0] MCK_ADDR_CTRL2 = 32'h0000_0004;
  localparam logic [31:0] MCK_ADDR_STATUS = 32'h0000_0008;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MCK_MODE_RUN = 2'h0;
  localparam logic [1:0] MCK_MODE_LOW = 2'h1;
  localparam logic [1:0] MCK_MODE_HIZ = 2'h2;
  localparam logic [1:0] MCK_DIV_1 = 2'h0;
  localparam logic [1:0] MCK_DIV_2 = 2'h1;
  localparam logic [1:0] MCK_DIV_4 = 2'h2;

  // ----------------------------------------------------------------
  // bus constants
  // ----------------------------------------------------------------
  localparam logic [1:0] MCK_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] MCK_HSIZE_WORD = 3'h2;
  localparam logic [31:0] MCK_RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode;
  } mck_ctrl1_t;

  typedef struct packed {
    logic [1:0] div;
    logic [1:0] mode;
  } mck_ctrl2_t;

  typedef struct packed {
    logic holdActive;
    logic srcExternal;
    logic strapHold;
    logic strapValid;
  } mck_status_t;

  localparam mck_ctrl1_t MCK_CTRL1_RST = '{mode: MCK_MODE_HIZ};
  localparam mck_ctrl2_t MCK_CTRL2_RST = '{div: MCK_DIV_4, mode: MCK_MODE_RUN};

  localparam logic [1:0] MCK_DIVCNT_RST = 2'h0;
  localparam logic [1:0] MCK_DIVCNT_STEP = 2'h1;

endpackage

// File: mck_clock_hold.sv
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module mck_clock_hold (
  // clock and resets
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic porN,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // straps and clock sources
  input wire logic resetConfigStrap,
  input wire logic memifClockSourceSelect,
  input wire logic memifExternalClockIn,
  input wire logic internalSystemClockThree,
  // bus release
  input wire logic busReleaseRequestN,
  output logic memifBusOe,
  // shared parallel port pin
  input wire logic sharedParallelPortPinIn,
  output logic sharedParallelPortPinOut,
  output logic sharedParallelPortPinOe,
  output logic parallelPortIoLine,
  // memory interface clock outputs
  output logic memifClockOutFirstOut,
  output logic memifClockOutFirstOe,
  output logic memifClockOutSecondOut,
  output logic memifClockOutSecondOe
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addrHit(input logic [31:0] a, input logic [31:0] base);
    addrHit = (a == base);
  endfunction

  function automatic logic divTap(input logic [1:0] div, input logic lvl, input logic [1:0] cnt);
    if (div == mck_pkg::MCK_DIV_1) begin
      divTap = lvl;
    end else if (div == mck_pkg::MCK_DIV_2) begin
      divTap = cnt[0];
    end else begin
      divTap = cnt[1];
    end
  endfunction

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  // kept on the power-on reset so straps and clocks are tracked while rstn is low;
  // external clocks must stay below a quarter of ref_clk to be seen reliably
  logic strapS1, strapS2;
  logic srcS1, srcS2;
  logic eclkS1, eclkS2, eclkS3;
  logic sclkS1, sclkS2, sclkS3;
  logic reqS1, reqS2;
  logic pinS1, pinS2;

  always_ff @(posedge ref_clk or negedge porN) begin
    if (!porN) begin
      strapS1 <= 1'b0;
      strapS2 <= 1'b0;
      srcS1 <= 1'b0;
      srcS2 <= 1'b0;
      reqS1 <= 1'b1;
      reqS2 <= 1'b1;
      pinS1 <= 1'b0;
      pinS2 <= 1'b0;
    end else begin
      strapS1 <= resetConfigStrap;
      strapS2 <= strapS1;
      srcS1 <= memifClockSourceSelect;
      srcS2 <= srcS1;
      reqS1 <= busReleaseRequestN;
      reqS2 <= reqS1;
      pinS1 <= sharedParallelPortPinIn;
      pinS2 <= pinS1;
    end
  end

  always_ff @(posedge ref_clk or negedge porN) begin
    if (!porN) begin
      eclkS1 <= 1'b0;
      eclkS2 <= 1'b0;
      eclkS3 <= 1'b0;
      sclkS1 <= 1'b0;
      sclkS2 <= 1'b0;
      sclkS3 <= 1'b0;
    end else begin
      eclkS1 <= memifExternalClockIn;
      eclkS2 <= eclkS1;
      eclkS3 <= eclkS2;
      sclkS1 <= internalSystemClockThree;
      sclkS2 <= sclkS1;
      sclkS3 <= sclkS2;
    end
  end

  // ----------------------------------------------------------------
  // memory interface clock source
  // ----------------------------------------------------------------
  logic memifClkLvl;
  logic memifClkPrev;
  logic memifRise;

  assign memifClkLvl = srcS2 ? eclkS2 : sclkS2;
  assign memifClkPrev = srcS2 ? eclkS3 : sclkS3;
  assign memifRise = memifClkLvl & ~memifClkPrev;

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // taken on the first edge after release; the synchroniser has followed the
  // strap all through reset, so this is the level held during reset
  logic strapValid;
  logic strapHold;
  logic strapSrc;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strapValid <= 1'b0;
      strapHold <= 1'b0;
      strapSrc <= 1'b0;
    end else if (!strapValid) begin
      strapValid <= 1'b1;
      strapHold <= strapS2;
      strapSrc <= srcS2;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic dataWrite;
  logic [31:0] dataAddr;
  mck_pkg::mck_ctrl1_t ctrl1;
  mck_pkg::mck_ctrl2_t ctrl2;
  mck_pkg::mck_status_t status;
  logic eclkFollow;
  logic addrPhase;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel & hready & (htrans == mck_pkg::MCK_HTRANS_NONSEQ);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dataWrite <= 1'b0;
      dataAddr <= mck_pkg::MCK_RDATA_ZERO;
    end else begin
      dataWrite <= addrPhase & hwrite & (hsize == mck_pkg::MCK_HSIZE_WORD);
      dataAddr <= haddr;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= mck_pkg::MCK_RDATA_ZERO;
    end else if (addrPhase & ~hwrite) begin
      if (addrHit(haddr, mck_pkg::MCK_ADDR_CTRL1)) begin
        hrdata <= {30'h0000_0000, ctrl1};
      end else if (addrHit(haddr, mck_pkg::MCK_ADDR_CTRL2)) begin
        hrdata <= {28'h000_0000, ctrl2};
      end else if (addrHit(haddr, mck_pkg::MCK_ADDR_STATUS)) begin
        hrdata <= {28'h000_0000, status};
      end else begin
        hrdata <= mck_pkg::MCK_RDATA_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // the post-reset pattern is loaded in the capture cycle; a bus write in the
  // same cycle is impossible since no transfer completes that early
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl1 <= mck_pkg::MCK_CTRL1_RST;
      eclkFollow <= 1'b0;
    end else if (!strapValid) begin
      if (!strapS2 && !srcS2) begin
        ctrl1.mode <= mck_pkg::MCK_MODE_HIZ;
        eclkFollow <= 1'b0;
      end else begin
        ctrl1.mode <= mck_pkg::MCK_MODE_RUN;
        eclkFollow <= 1'b1;
      end
    end else if (dataWrite && addrHit(dataAddr, mck_pkg::MCK_ADDR_CTRL1)) begin
      ctrl1 <= hwdata[1:0];
      eclkFollow <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl2 <= mck_pkg::MCK_CTRL2_RST;
    end else if (!strapValid) begin
      ctrl2.div <= mck_pkg::MCK_DIV_4;
      if (!strapS2 && !srcS2) begin
        ctrl2.mode <= mck_pkg::MCK_MODE_LOW;
      end else begin
        ctrl2.mode <= mck_pkg::MCK_MODE_RUN;
      end
    end else if (dataWrite && addrHit(dataAddr, mck_pkg::MCK_ADDR_CTRL2)) begin
      ctrl2 <= hwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // first clock output
  // ----------------------------------------------------------------
  // right after a reset with the strap or the source select high it mirrors the external input until software rewrites
  // the mode, even when the interface itself runs from the internal clock
  logic clk1Src;

  assign clk1Src = eclkFollow ? eclkS2 : memifClkLvl;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      memifClockOutFirstOut <= 1'b0;
      memifClockOutFirstOe <= 1'b0;
    end else begin
      case (ctrl1.mode)
        mck_pkg::MCK_MODE_RUN: begin
          memifClockOutFirstOut <= clk1Src;
          memifClockOutFirstOe <= 1'b1;
        end
        mck_pkg::MCK_MODE_LOW: begin
          memifClockOutFirstOut <= 1'b0;
          memifClockOutFirstOe <= 1'b1;
        end
        default: begin
          memifClockOutFirstOut <= 1'b0;
          memifClockOutFirstOe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // second clock output
  // ----------------------------------------------------------------
  // on the power-on reset so the divider keeps running while rstn is low
  logic [1:0] divCnt;

  always_ff @(posedge ref_clk or negedge porN) begin
    if (!porN) begin
      divCnt <= mck_pkg::MCK_DIVCNT_RST;
    end else if (memifRise) begin
      divCnt <= divCnt + mck_pkg::MCK_DIVCNT_STEP;
    end
  end

  always_ff @(posedge ref_clk or negedge porN) begin
    if (!porN) begin
      memifClockOutSecondOut <= 1'b0;
      memifClockOutSecondOe <= 1'b0;
    end else begin
      case (ctrl2.mode)
        mck_pkg::MCK_MODE_RUN: begin
          memifClockOutSecondOut <= divTap(ctrl2.div, memifClkLvl, divCnt);
          memifClockOutSecondOe <= 1'b1;
        end
        mck_pkg::MCK_MODE_LOW: begin
          memifClockOutSecondOut <= 1'b0;
          memifClockOutSecondOe <= 1'b1;
        end
        default: begin
          memifClockOutSecondOut <= 1'b0;
          memifClockOutSecondOe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus release handshake
  // ----------------------------------------------------------------
  // the bus is floated before the acknowledge goes out and driven again one
  // cycle after it is withdrawn, so the two masters never overlap
  typedef enum logic [1:0] {HOLD_RUN, HOLD_FLOAT, HOLD_HELD, HOLD_RESUME} mck_hold_t;
  mck_hold_t holdState;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      holdState <= HOLD_RUN;
    end else begin
      case (holdState)
        HOLD_RUN: begin
          if (strapValid && strapHold && !reqS2) begin
            holdState <= HOLD_FLOAT;
          end
        end
        HOLD_FLOAT: begin
          holdState <= HOLD_HELD;
        end
        HOLD_HELD: begin
          if (reqS2) begin
            holdState <= HOLD_RESUME;
          end
        end
        default: begin
          holdState <= HOLD_RUN;
        end
      endcase
    end
  end

  assign memifBusOe = (holdState == HOLD_RUN);

  // ----------------------------------------------------------------
  // shared pin
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sharedParallelPortPinOe <= 1'b0;
      sharedParallelPortPinOut <= 1'b0;
      parallelPortIoLine <= 1'b0;
    end else if (strapValid && strapHold) begin
      sharedParallelPortPinOe <= 1'b1;
      sharedParallelPortPinOut <= !(holdState == HOLD_HELD && !reqS2);
      parallelPortIoLine <= 1'b0;
    end else begin
      sharedParallelPortPinOe <= 1'b0;
      sharedParallelPortPinOut <= 1'b0;
      parallelPortIoLine <= pinS2;
    end
  end

  assign status = '{holdActive: (holdState == HOLD_HELD), srcExternal: srcS2,
                    strapHold: strapHold, strapValid: strapValid};

endmodule // mck_clock_hold

// File: mck_clock_hold_monitor.sv
`timescale 1ns/1ps
module mck_clock_hold_monitor (
  // clock and resets
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic porN,
  // bus activity
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  // straps and request
  input wire logic resetConfigStrap,
  input wire logic memifClockSourceSelect,
  input wire logic busReleaseRequestN,
  // pins
  input wire logic memifBusOe,
  input wire logic sharedParallelPortPinIn,
  input wire logic sharedParallelPortPinOut,
  input wire logic sharedParallelPortPinOe,
  input wire logic parallelPortIoLine,
  input wire logic memifClockOutFirstOe,
  input wire logic memifClockOutSecondOut,
  input wire logic memifClockOutSecondOe
);
  logic strapLat;
  logic wrSeen;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!porN);
  // strap as the device should hold it; moves only inside reset
  always_ff @(posedge ref_clk or negedge porN) begin
    if (!porN) begin
      strapLat <= 1'h0;
    end else if (!rstn) begin
      strapLat <= resetConfigStrap;
    end
  end
  // post-reset clock pattern only holds until software writes a control word
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrSeen <= 1'h0;
    end else if (hsel && hwrite && htrans == mck_pkg::MCK_HTRANS_NONSEQ) begin
      wrSeen <= 1'h1;
    end
  end
  sequence s_grant;
    !memifBusOe ##[1:3] !sharedParallelPortPinOut;
  endsequence
  sequence s_resume;
    sharedParallelPortPinOut ##[1:3] memifBusOe;
  endsequence
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_clk1_rst_float: assert property (!rstn |-> !memifClockOutFirstOe)
    else $error("clock one driven in reset");
  a_pin_rst_float: assert property (!rstn |-> !sharedParallelPortPinOe)
    else $error("shared pin driven in reset");
  a_clk2_rst_run: assert property (!rstn && !$past(rstn) && $past(porN, 2) |-> memifClockOutSecondOe)
    else $error("clock two off in reset");
  a_gpio_is_input: assert property (rstn && !strapLat |-> !sharedParallelPortPinOe)
    else $error("gpio pin driven");
  a_ack_drives_one: assert property (rstn && $past(rstn, 4) && strapLat |-> sharedParallelPortPinOe)
    else $error("acknowledge pin not driven");
  a_pin_fn_fixed: assert property (rstn && $past(rstn, 5) |-> $stable(sharedParallelPortPinOe))
    else $error("pin function moved");
  a_gpio_follows: assert property ((rstn && !strapLat && $stable(sharedParallelPortPinIn))[*6]
    |-> parallelPortIoLine == sharedParallelPortPinIn)
    else $error("gpio line stale");
  a_ack_bus_free: assert property (sharedParallelPortPinOe && !sharedParallelPortPinOut |-> !memifBusOe)
    else $error("acknowledge with bus driven");
  a_hold_grant: assert property (rstn && strapLat && $fell(busReleaseRequestN) |-> ##[1:6] s_grant)
    else $error("hold not granted");
  a_hold_resume: assert property (rstn && strapLat && $rose(busReleaseRequestN) |-> ##[1:6] s_resume)
    else $error("hold not ended");
  a_clk1_post_float: assert property (rstn && $past(rstn, 4) && !wrSeen && !strapLat
    && !memifClockSourceSelect |-> !memifClockOutFirstOe)
    else $error("clock one driven after reset");
  a_clk1_post_run: assert property (rstn && $past(rstn, 4) && !wrSeen
    && (strapLat || memifClockSourceSelect) |-> memifClockOutFirstOe)
    else $error("clock one off after reset");
  a_clk2_post_low: assert property (rstn && $past(rstn, 4) && !wrSeen && !strapLat
    && !memifClockSourceSelect |-> memifClockOutSecondOe && !memifClockOutSecondOut)
    else $error("clock two not low");
endmodule // mck_clock_hold_monitor

bind mck_clock_hold mck_clock_hold_monitor u_mon (.ref_clk, .rstn, .porN, .hsel, .htrans, .hwrite,
  .resetConfigStrap, .memifClockSourceSelect, .busReleaseRequestN, .memifBusOe, .sharedParallelPortPinIn,
  .sharedParallelPortPinOut, .sharedParallelPortPinOe, .parallelPortIoLine, .memifClockOutFirstOe,
  .memifClockOutSecondOut, .memifClockOutSecondOe);

// File: mck_far_side.sv
`timescale 1ns/1ps
module mck_far_side (
  // commands from the bench
  input wire logic wantBus,
  input wire logic gpioVal,
  // device side of the shared pin
  input wire logic devOut,
  input wire logic devOe,
  // lines toward the device
  output logic eclk,
  output logic reqN,
  output logic pinLevel
);
  initial eclk = 1'h0;
  initial reqN = 1'h1;
  always #20 eclk = ~eclk;
  // the requester runs unrelated to the device, so the request lands between edges
  always @(wantBus) reqN <= #13 !wantBus;
  // device wins the pin when enabled, else the outside gpio source drives it
  assign pinLevel = devOe ? devOut : gpioVal;
endmodule // mck_far_side

// File: mck_clock_hold_tb.sv
`timescale 1ns/1ps
module mck_clock_hold_tb;
  logic ref_clk = 1'h0, rstn = 1'h0, porN = 1'h0, hsel = 1'h0, hwrite = 1'h0, sys3 = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = mck_pkg::MCK_HSIZE_WORD;
  logic resetConfigStrap = 1'h0, memifClockSourceSelect = 1'h0, wantBus = 1'h0, gpioVal = 1'h0;
  logic hreadyout, hresp, eclk, reqN, pinLevel, memifBusOe, pinOut, pinOe, parallelPortIoLine;
  logic c1Out, c1Oe, c2Out, c2Oe;
  int n_mismatch = 0, checks = 0, n1, n2;
  always #2.5 ref_clk = ~ref_clk;
  always #30 sys3 = ~sys3;
  mck_clock_hold uut (.ref_clk, .rstn, .porN, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .resetConfigStrap, .memifClockSourceSelect,
    .memifExternalClockIn(eclk), .internalSystemClockThree(sys3), .busReleaseRequestN(reqN), .memifBusOe,
    .sharedParallelPortPinIn(pinLevel), .sharedParallelPortPinOut(pinOut), .sharedParallelPortPinOe(pinOe),
    .parallelPortIoLine, .memifClockOutFirstOut(c1Out), .memifClockOutFirstOe(c1Oe),
    .memifClockOutSecondOut(c2Out), .memifClockOutSecondOe(c2Oe));
  mck_far_side far (.wantBus, .gpioVal, .devOut(pinOut), .devOe(pinOe), .eclk, .reqN, .pinLevel);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task rng(input int got, lo, hi, input string m);
    chk(32'(got >= lo && got <= hi), 32'h1, m);
  endtask
  task bus(input logic w, input logic [31:0] a, d);
    @(posedge ref_clk);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= mck_pkg::MCK_HTRANS_NONSEQ;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
    chk(hresp, 1'h0, "response not okay");
  endtask
  // 240 cycles is 1200 ns: 30 external and 20 internal source periods
  task meas;
    logic p1, p2, bad;
    p1 = c1Out;
    p2 = c2Out;
    bad = 1'h0;
    n1 = 0;
    n2 = 0;
    repeat (240) begin
      @(posedge ref_clk);
      bad |= $isunknown({c1Out, c2Out});
      n1 += int'(c1Out && !p1);
      n2 += int'(c2Out && !p2);
      p1 = c1Out;
      p2 = c2Out;
    end
    chk(bad, 1'h0, "clock unknown");
  endtask
  task cfg(input logic [31:0] a, d, input int lo, hi, input logic oe);
    bus(1'h1, a, d);
    repeat (4) @(posedge ref_clk);
    meas;
    rng(a == mck_pkg::MCK_ADDR_CTRL1 ? n1 : n2, lo, hi, "clock rate");
    chk(a == mck_pkg::MCK_ADDR_CTRL1 ? c1Oe : c2Oe, oe, "clock enable");
  endtask
  task rst(input logic s, c);
    @(posedge ref_clk);
    rstn <= 1'h0;
    resetConfigStrap <= s;
    memifClockSourceSelect <= c;
    repeat (4) @(posedge ref_clk);
    chk(c1Oe, 1'h0, "clock one in reset");
    chk(pinOe, 1'h0, "pin in reset");
    meas;
    rng(n2, c ? 6 : 4, c ? 9 : 6, "clock two in reset");
    rstn <= 1'h1;
    repeat (6) @(posedge ref_clk);
    meas;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #100000;
    n_mismatch++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    porN <= 1'h1;
    @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (4) @(posedge ref_clk);
    bus(1'h0, mck_pkg::MCK_ADDR_STATUS, 32'h0);
    chk(rd, 32'h1, "status gpio");
    bus(1'h0, mck_pkg::MCK_ADDR_CTRL1, 32'h0);
    chk(rd, 32'h2, "ctrl1 reset");
    bus(1'h0, mck_pkg::MCK_ADDR_CTRL2, 32'h0);
    chk(rd, 32'h9, "ctrl2 reset");
    meas;
    rng(n1 + n2, 0, 0, "clocks idle");
    chk({c1Oe, c2Oe, c2Out, pinOe}, 4'h4, "post reset pins");
    gpioVal <= 1'h1;
    wantBus <= 1'h1;
    repeat (20) @(posedge ref_clk);
    chk(parallelPortIoLine, 1'h1, "gpio high");
    chk(memifBusOe, 1'h1, "hold ignored");
    gpioVal <= 1'h0;
    wantBus <= 1'h0;
    repeat (8) @(posedge ref_clk);
    chk(parallelPortIoLine, 1'h0, "gpio low");
    cfg(mck_pkg::MCK_ADDR_CTRL2, 32'h0, 19, 21, 1'h1);
    cfg(mck_pkg::MCK_ADDR_CTRL2, 32'h4, 9, 11, 1'h1);
    cfg(mck_pkg::MCK_ADDR_CTRL2, 32'h8, 4, 6, 1'h1);
    cfg(mck_pkg::MCK_ADDR_CTRL2, 32'h1, 0, 0, 1'h1);
    chk(c2Out, 1'h0, "clock two held low");
    cfg(mck_pkg::MCK_ADDR_CTRL2, 32'h2, 0, 0, 1'h0);
    bus(1'h0, 32'h0000_000C, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    cfg(mck_pkg::MCK_ADDR_CTRL1, 32'h0, 19, 21, 1'h1);
    cfg(mck_pkg::MCK_ADDR_CTRL1, 32'h1, 0, 0, 1'h1);
    cfg(mck_pkg::MCK_ADDR_CTRL1, 32'h2, 0, 0, 1'h0);
    rst(1'h1, 1'h0);
    rng(n1, 29, 31, "clock one external");
    rng(n2, 4, 6, "clock two internal quarter");
    chk({pinOe, pinOut}, 2'h3, "acknowledge idle");
    resetConfigStrap <= 1'h0;
    wantBus <= 1'h1;
    repeat (12) @(posedge ref_clk);
    chk({pinOe, pinOut, memifBusOe}, 3'h4, "bus held");
    bus(1'h0, mck_pkg::MCK_ADDR_STATUS, 32'h0);
    chk(rd, 32'hB, "status held");
    wantBus <= 1'h0;
    repeat (12) @(posedge ref_clk);
    chk({pinOut, memifBusOe}, 2'h3, "bus resumed");
    rst(1'h0, 1'h1);
    rng(n1, 29, 31, "clock one external");
    rng(n2, 6, 9, "clock two external quarter");
    bus(1'h0, mck_pkg::MCK_ADDR_STATUS, 32'h0);
    chk(rd, 32'h5, "status external");
    cfg(mck_pkg::MCK_ADDR_CTRL1, 32'h0, 29, 31, 1'h1);
    rst(1'h1, 1'h1);
    rng(n1, 29, 31, "clock one both high");
    rng(n2, 6, 9, "clock two both high");
    summarize;
  end
endmodule // mck_clock_hold_tb
